// ---- sdt_timer.sv ----
/*
 * split dual byte timer: two 8-bit down counters with an apb slave.
 * assumes apb on pclk, cpu_halted synchronous to pclk.
 */
// The implementer's own choice: register access over APB.
// Contract
// - stopped timer drives each wave output from its output value bit.
// - output value writes take effect only while the timer is stopped.
// - split select bit 0 runs two independent 8-bit counters.
// - split-only registers are mapped only while split select is set.
// - writing one to the clear register clears only that bit.
// - writing one to the set register sets only that bit.
// - set and clear registers read back the same state.
// - command 1 update, 2 restart, 3 hard reset, 0 nothing.
// - command field always reads zero.
// - hard reset command ignored while the timer is enabled.
// - low compare enables bits 6:4 gate compare interrupts.
// - enable bit 1 gates high underflow interrupt.
// - enable bit 0 gates low underflow interrupt.
// - low compare flag set on a tick when low count equals channel compare.
// - compare flags stay set until software writes one.
// - high underflow flag set when high count reaches zero, sticky.
// - low underflow flag set when low count reaches zero, sticky.
// - without debug run the timer freezes while cpu is halted.
// - bus write to a counter beats count, clear or reload.
// - low period register is the low counter top.
// - high period register is the high counter top.
// - low compare values continuously compared, drive waveforms.
// - high compare values continuously compared to high counter.
// - clock select divides by 1,2,4,8,16,64,256,1024.
`timescale 1ns/1ps
module sdt_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cpu_halted,
    output logic [5:0] wave_out_pin,
    output logic irq
);
    import sdt_pkg::*;

    sdt_state_type q;
    sdt_state_type d;

    // ==========================================================
    // bus decode
    logic setup;
    logic acc;
    logic wr;
    logic [5:0] idx;
    logic [7:0] wb;
    logic split_on;
    logic addr_ok;
    logic [7:0] rd_val;

    assign setup = psel & ~penable;
    assign acc = psel & penable & q.pready;
    assign idx = paddr[7:2];
    assign wb = pwdata[7:0];
    assign split_on = q.split[SPLIT_BIT];
    assign wr = acc & pwrite & pstrb[0] & ~q.pslverr;

    // read mux and map check; counter block hidden outside split
    always_comb begin
        rd_val = 8'h00;
        addr_ok = 1'b1;
        case (idx)
            IDX_CTRLA: rd_val = q.ctrla;
            IDX_CTRLB: rd_val = q.ctrlb;
            IDX_OVAL: rd_val = q.oval;
            IDX_SPLIT: rd_val = q.split;
            IDX_ECLR, IDX_ESET: rd_val = {6'h00, q.hold, 1'b0};
            IDX_INTEN: rd_val = q.inten;
            IDX_FLAGS: rd_val = q.flags;
            IDX_DBG: rd_val = q.dbg;
            IDX_LOW_COUNT: rd_val = q.low_count;
            IDX_HIGH_COUNT: rd_val = q.high_count;
            IDX_LOW_TOP: rd_val = q.low_top;
            IDX_HIGH_TOP: rd_val = q.high_top;
            6'h28, 6'h2a, 6'h2c: rd_val = q.low_cmp[(idx - IDX_LOW_CMP0) >> 1];
            6'h29, 6'h2b, 6'h2d: rd_val = q.high_cmp[(idx - IDX_HIGH_CMP0) >> 1];
            default: addr_ok = 1'b0;
        endcase
        if (idx >= IDX_LOW_COUNT && !split_on) begin
            addr_ok = 1'b0;
            rd_val = 8'h00;
        end
        if (paddr[1:0] != 2'h0) begin
            addr_ok = 1'b0;
        end
    end

    // ==========================================================
    // prescaler, run gating and commands
    logic run;
    logic tick;
    logic [1:0] cmd;
    logic cmd_wr;
    logic restart;
    logic hreset;
    logic lc_wr;
    logic hc_wr;

    assign run = q.ctrla[EN_BIT] & split_on & ~q.hold
        & (q.dbg[DEBUG_RUN_BIT] | ~cpu_halted);
    assign tick = run & ((q.presc & sdt_div_mask(q.ctrla[3:1]))
        == sdt_div_mask(q.ctrla[3:1]));
    assign cmd = wb[CMD_LSB+1:CMD_LSB];
    assign cmd_wr = wr & (idx == IDX_ECLR || idx == IDX_ESET);
    assign restart = cmd_wr & (cmd == CMD_RESTART);
    assign hreset = cmd_wr & (cmd == CMD_HRESET) & ~q.ctrla[EN_BIT];
    assign lc_wr = wr & split_on & (idx == IDX_LOW_COUNT);
    assign hc_wr = wr & split_on & (idx == IDX_HIGH_COUNT);

    // ==========================================================
    // per-channel comparators and waveform levels
    logic [2:0] lmatch;
    logic [2:0] hmatch;
    logic [5:0] wave_nxt;

    genvar n;
    generate
        for (n = 0; n < 3; n++) begin : g_chan
            assign lmatch[n] = q.low_count == q.low_cmp[n];
            assign hmatch[n] = q.high_count == q.high_cmp[n];
            // running with output on: high while count below compare
            assign wave_nxt[n] = (q.ctrla[EN_BIT] & q.ctrlb[n])
                ? (q.low_count < q.low_cmp[n]) : q.oval[n];
            assign wave_nxt[3+n] = (q.ctrla[EN_BIT] & q.ctrlb[HIGH_CH_LSB+n])
                ? (q.high_count < q.high_cmp[n]) : q.oval[HIGH_CH_LSB+n];
        end
    endgenerate

    // ==========================================================
    // next state
    always_comb begin
        logic [7:0] fset;
        logic [7:0] fclr;
        fset = 8'h00;
        fclr = 8'h00;
        d = q;
        // register writes
        if (wr) begin
            case (idx)
                IDX_CTRLA: d.ctrla = wb & CTRLA_MASK;
                IDX_CTRLB: d.ctrlb = wb & CHAN_MASK;
                IDX_OVAL: begin
                    if (!q.ctrla[EN_BIT]) begin
                        d.oval = wb & CHAN_MASK;
                    end
                end
                IDX_SPLIT: d.split = wb & ONE_MASK;
                IDX_ECLR: begin
                    if (wb[HOLD_BIT]) begin
                        d.hold = 1'b0;
                    end
                end
                IDX_ESET: begin
                    if (wb[HOLD_BIT]) begin
                        d.hold = 1'b1;
                    end
                end
                IDX_INTEN: d.inten = wb & IRQ_MASK;
                IDX_FLAGS: fclr = wb & IRQ_MASK;
                IDX_DBG: d.dbg = wb & ONE_MASK;
                IDX_LOW_TOP: d.low_top = split_on ? wb : q.low_top;
                IDX_HIGH_TOP: d.high_top = split_on ? wb : q.high_top;
                6'h28, 6'h2a, 6'h2c: begin
                    if (split_on) begin
                        d.low_cmp[(idx - IDX_LOW_CMP0) >> 1] = wb;
                    end
                end
                6'h29, 6'h2b, 6'h2d: begin
                    if (split_on) begin
                        d.high_cmp[(idx - IDX_HIGH_CMP0) >> 1] = wb;
                    end
                end
                default: d.ctrla = q.ctrla;
            endcase
        end
        // prescaler runs only while counting
        if (restart) begin
            d.presc = 10'h000;
        end else if (run) begin
            d.presc = q.presc + 10'h001;
        end
        // low counter: bus write first, then restart, then count
        if (lc_wr) begin
            d.low_count = wb;
        end else if (restart) begin
            d.low_count = 8'h00;
        end else if (tick) begin
            d.low_count = (q.low_count == 8'h00) ? q.low_top : q.low_count - 8'h01;
            fset[LOW_UNF_BIT] = q.low_count == 8'h01;
            fset[LMATCH_LSB +: 3] = lmatch;
        end
        // high counter, same order
        if (hc_wr) begin
            d.high_count = wb;
        end else if (restart) begin
            d.high_count = 8'h00;
        end else if (tick) begin
            d.high_count = (q.high_count == 8'h00) ? q.high_top : q.high_count - 8'h01;
            fset[HIGH_UNF_BIT] = q.high_count == 8'h01;
        end
        // sticky flags, a set in the clearing cycle wins
        d.flags = (q.flags & ~fclr) | fset;
        // hard reset returns every control and count to reset
        if (hreset) begin
            d.ctrla = RST_BYTE;
            d.ctrlb = RST_BYTE;
            d.oval = RST_BYTE;
            d.split = RST_BYTE;
            d.hold = 1'b0;
            d.inten = RST_BYTE;
            d.flags = RST_BYTE;
            d.dbg = RST_BYTE;
            d.low_count = RST_BYTE;
            d.high_count = RST_BYTE;
            d.low_top = RST_PER;
            d.high_top = RST_PER;
            d.low_cmp = '0;
            d.high_cmp = '0;
            d.presc = 10'h000;
        end
        d.wave = wave_nxt;
        d.irq = |(d.flags & d.inten);
        // apb answer: registered in setup, shown in the access cycle
        d.pready = setup;
        d.pslverr = setup & ~addr_ok;
        if (setup) begin
            d.prdata = (pwrite || !addr_ok) ? 32'h0000_0000 : {24'h000000, rd_val};
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign wave_out_pin = q.wave;
    assign irq = q.irq;

    // ==========================================================
    // assertions
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_wave_idle_value: assert property (
        !q.ctrla[EN_BIT] |=> wave_out_pin
            == {$past(q.oval[6:4]), $past(q.oval[2:0])})
        else $error("stopped wave output differs from value bits");
    a_oval_locked: assert property (
        wr && idx == IDX_OVAL && q.ctrla[EN_BIT] |=> $stable(q.oval))
        else $error("output value changed while running");
    a_clear_bit: assert property (
        wr && idx == IDX_ECLR && wb[HOLD_BIT] && !(hreset) |=> !q.hold)
        else $error("clear register did not clear bit");
    a_set_bit: assert property (
        wr && idx == IDX_ESET && wb[HOLD_BIT] && !(hreset) |=> q.hold)
        else $error("set register did not set bit");
    a_cmd_reads_zero: assert property (
        setup && !pwrite && (idx == IDX_ECLR || idx == IDX_ESET)
            |=> pready && prdata[3:2] == 2'h0)
        else $error("command field read nonzero");
    a_hreset_ignored: assert property (
        cmd_wr && cmd == CMD_HRESET && q.ctrla[EN_BIT] |=> q.ctrla[EN_BIT])
        else $error("hard reset acted while enabled");
    a_low_unf_sets: assert property (
        tick && q.low_count == 8'h01 && !lc_wr && !restart && !hreset
            |=> q.flags[LOW_UNF_BIT])
        else $error("low underflow flag missed");
    a_high_unf_sets: assert property (
        tick && q.high_count == 8'h01 && !hc_wr && !restart && !hreset
            |=> q.flags[HIGH_UNF_BIT])
        else $error("high underflow flag missed");
    a_flag_sticky: assert property (
        q.flags[LMATCH_LSB] && !(wr && idx == IDX_FLAGS && wb[LMATCH_LSB])
            && !hreset |=> q.flags[LMATCH_LSB])
        else $error("compare flag dropped without clear");
    a_halt_freeze: assert property (
        cpu_halted && !q.dbg[DEBUG_RUN_BIT] && !wr
            |=> $stable(q.low_count) && $stable(q.high_count))
        else $error("counter moved during debug halt");
    a_cnt_write_wins: assert property (
        lc_wr |=> q.low_count == $past(wb))
        else $error("counter write lost");
    a_reload_top: assert property (
        tick && q.low_count == 8'h00 && !lc_wr && !restart && !hreset
            |=> q.low_count == $past(q.low_top))
        else $error("low counter did not reload top");
    a_high_reload: assert property (
        tick && q.high_count == 8'h00 && !hc_wr && !restart && !hreset
            |=> q.high_count == $past(q.high_top))
        else $error("high counter did not reload top");
    a_low_step: assert property (
        tick && q.low_count != 8'h00 && !lc_wr && !restart && !hreset
            |=> q.low_count == $past(q.low_count) - 8'h01)
        else $error("low counter did not step down");
    a_low_match_flag: assert property (
        tick && lmatch[0] && !lc_wr && !restart && !hreset
            |=> q.flags[LMATCH_LSB])
        else $error("low compare flag missed");
    a_flag_clear: assert property (
        wr && idx == IDX_FLAGS && wb[LOW_UNF_BIT] && !tick && !hreset
            |=> !q.flags[LOW_UNF_BIT])
        else $error("flag not cleared by writing one");
    a_low_wave: assert property (
        q.ctrla[EN_BIT] && q.ctrlb[0]
            |=> wave_out_pin[0] == $past(q.low_count < q.low_cmp[0]))
        else $error("low compare waveform wrong");
    a_high_wave: assert property (
        q.ctrla[EN_BIT] && q.ctrlb[HIGH_CH_LSB]
            |=> wave_out_pin[3] == $past(q.high_count < q.high_cmp[0]))
        else $error("high compare waveform wrong");
    a_div_one: assert property (
        run && q.ctrla[3:1] == 3'h0 |-> tick)
        else $error("divide by one missed a tick");
    a_div_max: assert property (
        tick && q.ctrla[3:1] == 3'h7 |-> q.presc == 10'h3ff)
        else $error("divide by 1024 ticked early");
    a_split_gates_run: assert property (
        !split_on && !hreset && !restart
            |=> $stable(q.low_count) && $stable(q.high_count))
        else $error("counters moved outside split mode");
    a_split_write: assert property (
        wr && idx == IDX_SPLIT |=> q.split == ($past(wb) & ONE_MASK))
        else $error("split select write lost");
    a_map_hidden: assert property (
        setup && !split_on && idx >= IDX_LOW_COUNT |=> pslverr)
        else $error("split registers visible outside split mode");
    a_setclr_same: assert property (
        setup && !pwrite && (idx == IDX_ECLR || idx == IDX_ESET) && paddr[1:0] == 2'h0
            |=> prdata[HOLD_BIT] == $past(q.hold))
        else $error("set and clear read back differ");
    a_restart_zero: assert property (
        restart |=> q.low_count == 8'h00 && q.high_count == 8'h00)
        else $error("restart did not zero counters");
    a_irq_level: assert property (
        irq == |(q.flags & q.inten))
        else $error("interrupt level disagrees with flags");
    a_ready_once: assert property (
        setup |=> pready ##1 !pready)
        else $error("ready not a single cycle");

    // ==========================================================
    // covers of the main scenarios
    c_low_underflow: cover property (tick && q.low_count == 8'h01);
    c_restart: cover property (restart);
    c_hard_reset: cover property (hreset);
    c_irq_rise: cover property (!irq ##1 irq);
endmodule

// ---- sdt_pkg.sv ----
/*
 * constants, register map and state type of the split dual byte timer.
 * assumes an apb master on pclk; word index = byte address / 4.
 */
package sdt_pkg;
    // ==========================================================
    // register indices (byte address is four times the index)
    localparam logic [5:0] IDX_CTRLA = 6'h00;
    localparam logic [5:0] IDX_CTRLB = 6'h01;
    localparam logic [5:0] IDX_OVAL = 6'h02;
    localparam logic [5:0] IDX_SPLIT = 6'h03;
    localparam logic [5:0] IDX_ECLR = 6'h04;
    localparam logic [5:0] IDX_ESET = 6'h05;
    localparam logic [5:0] IDX_INTEN = 6'h0a;
    localparam logic [5:0] IDX_FLAGS = 6'h0b;
    localparam logic [5:0] IDX_DBG = 6'h0e;
    localparam logic [5:0] IDX_LOW_COUNT = 6'h20;
    localparam logic [5:0] IDX_HIGH_COUNT = 6'h21;
    localparam logic [5:0] IDX_LOW_TOP = 6'h26;
    localparam logic [5:0] IDX_HIGH_TOP = 6'h27;
    localparam logic [5:0] IDX_LOW_CMP0 = 6'h28;
    localparam logic [5:0] IDX_HIGH_CMP0 = 6'h29;
    // ==========================================================
    // field positions and writable masks
    localparam int EN_BIT = 0;
    localparam int SPLIT_BIT = 0;
    localparam int DEBUG_RUN_BIT = 0;
    localparam int HOLD_BIT = 1;
    localparam int CMD_LSB = 2;
    localparam int LOW_UNF_BIT = 0;
    localparam int HIGH_UNF_BIT = 1;
    localparam int LMATCH_LSB = 4;
    localparam int HIGH_CH_LSB = 4;
    localparam logic [7:0] CTRLA_MASK = 8'h0f;
    localparam logic [7:0] CHAN_MASK = 8'h77;
    localparam logic [7:0] IRQ_MASK = 8'h73;
    localparam logic [7:0] ONE_MASK = 8'h01;
    // ==========================================================
    // command codes and reset values
    localparam logic [1:0] CMD_NONE = 2'h0;
    localparam logic [1:0] CMD_UPDATE = 2'h1;
    localparam logic [1:0] CMD_RESTART = 2'h2;
    localparam logic [1:0] CMD_HRESET = 2'h3;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_PER = 8'h00;

    // whole state of the timer, one register set
    typedef struct packed {
        logic [7:0] ctrla;
        logic [7:0] ctrlb;
        logic [7:0] oval;
        logic [7:0] split;
        logic hold;
        logic [7:0] inten;
        logic [7:0] flags;
        logic [7:0] dbg;
        logic [7:0] low_count;
        logic [7:0] high_count;
        logic [7:0] low_top;
        logic [7:0] high_top;
        logic [2:0][7:0] low_cmp;
        logic [2:0][7:0] high_cmp;
        logic [9:0] presc;
        logic [5:0] wave;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } sdt_state_type;

    // prescaler mask: tick when the masked bits are all ones
    function automatic logic [9:0] sdt_div_mask(input logic [2:0] sel);
        case (sel)
            3'h0: sdt_div_mask = 10'h000;
            3'h1: sdt_div_mask = 10'h001;
            3'h2: sdt_div_mask = 10'h003;
            3'h3: sdt_div_mask = 10'h007;
            3'h4: sdt_div_mask = 10'h00f;
            3'h5: sdt_div_mask = 10'h03f;
            3'h6: sdt_div_mask = 10'h0ff;
            default: sdt_div_mask = 10'h3ff;
        endcase
    endfunction
endpackage

// ---- tb_split_dual_byte_timer.sv ----
/*
 * self-checking testbench of the split dual byte timer, driven over apb.
 * assumes sdt_pkg and sdt_timer are compiled first; pclk at 100 mhz.
 */
`timescale 1ns/1ps
module tb_split_dual_byte_timer;
    import sdt_pkg::*;
    // ==========================================================
    // signals
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic cpu_halted = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [5:0] wave_out_pin;
    logic irq;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [31:0] rv;
    logic [5:0] zero_list [9] = '{IDX_CTRLA, IDX_CTRLB, IDX_OVAL, IDX_SPLIT, IDX_ECLR,
                                  IDX_ESET, IDX_INTEN, IDX_FLAGS, IDX_DBG};

    sdt_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cpu_halted(cpu_halted),
        .wave_out_pin(wave_out_pin), .irq(irq));

    // clock and hang guard
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            wrap_up();
        end
    end

    // ==========================================================
    // checking and bus tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one apb transfer: setup, then access until pready
    task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] d,
                        output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) check(32'h1, 32'h0);
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        xfer(1'b1, idx, d, r, e);
        check({31'h0, e}, 32'h0);
    endtask

    task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
        logic [31:0] r;
        logic e;
        xfer(1'b0, idx, 8'h00, r, e);
        check(r, {24'h0, exp});
        check({31'h0, e}, 32'h0);
    endtask

    task automatic rd_err(input logic [5:0] idx);
        logic [31:0] r;
        logic e;
        xfer(1'b0, idx, 8'h00, r, e);
        check(r, 32'h0);
        check({31'h0, e}, 32'h1);
    endtask

    task automatic rd_val(input logic [5:0] idx, output logic [31:0] r);
        logic e;
        xfer(1'b0, idx, 8'h00, r, e);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // let the timer run for n+3 cycles between releasing and setting hold
    task automatic run_for(input int n);
        wr(IDX_ECLR, 8'h02);
        wait_cyc(n);
        wr(IDX_ESET, 8'h02);
    endtask

    task automatic test_end(input string name);
        $display("test %s finished", name);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // test sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // reset values and map refusals
        foreach (zero_list[i]) rd_chk(zero_list[i], 8'h00);
        check({26'h0, wave_out_pin}, 32'h0);
        rd_err(IDX_LOW_COUNT);
        rd_err(6'h06);
        // a write without its byte strobe is dropped
        pstrb <= 4'h0;
        wr(IDX_DBG, 8'h01);
        pstrb <= 4'hf;
        rd_chk(IDX_DBG, 8'h00);
        test_end("reset");
        // output values while stopped, then ignored while enabled
        wr(IDX_OVAL, 8'h25);
        wait_cyc(2);
        check({26'h0, wave_out_pin}, 32'h15);
        wr(IDX_CTRLA, 8'h01);
        wr(IDX_OVAL, 8'h52);
        wait_cyc(2);
        check({26'h0, wave_out_pin}, 32'h15);
        rd_chk(IDX_OVAL, 8'h25);
        wr(IDX_CTRLA, 8'h00);
        test_end("outputs");
        // set and clear registers share one state
        wr(IDX_ESET, 8'h02);
        rd_chk(IDX_ECLR, 8'h02);
        rd_chk(IDX_ESET, 8'h02);
        wr(IDX_ESET, 8'h04);
        rd_chk(IDX_ESET, 8'h02);
        wr(IDX_ECLR, 8'h00);
        rd_chk(IDX_ECLR, 8'h02);
        wr(IDX_ECLR, 8'h02);
        rd_chk(IDX_ESET, 8'h00);
        wr(IDX_ESET, 8'h02);
        test_end("setclr");
        // split mode counting, flags and interrupt gating
        wr(IDX_SPLIT, 8'h01);
        rd_chk(IDX_LOW_COUNT, 8'h00);
        wr(IDX_LOW_TOP, 8'h03);
        wr(IDX_HIGH_COUNT, 8'h01);
        wr(IDX_LOW_COUNT, 8'h02);
        rd_chk(IDX_LOW_COUNT, 8'h02);
        wr(IDX_CTRLA, 8'h01);
        run_for(20);
        rd_chk(IDX_FLAGS, 8'h73);
        wait_cyc(2);
        check({31'h0, irq}, 32'h0);
        wr(IDX_INTEN, 8'h01);
        wait_cyc(2);
        check({31'h0, irq}, 32'h1);
        wr(IDX_FLAGS, 8'h10);
        rd_chk(IDX_FLAGS, 8'h63);
        wr(IDX_INTEN, 8'h10);
        wait_cyc(2);
        check({31'h0, irq}, 32'h0);
        wr(IDX_INTEN, 8'h20);
        wait_cyc(2);
        check({31'h0, irq}, 32'h1);
        wr(IDX_INTEN, 8'h02);
        wait_cyc(2);
        check({31'h0, irq}, 32'h1);
        wr(IDX_FLAGS, 8'h63);
        rd_chk(IDX_FLAGS, 8'h00);
        wait_cyc(2);
        check({31'h0, irq}, 32'h0);
        test_end("counting");
        // halted cpu freezes the timer unless debug run is set
        wr(IDX_LOW_TOP, 8'hff);
        wr(IDX_LOW_COUNT, 8'h80);
        cpu_halted <= 1'b1;
        run_for(20);
        rd_chk(IDX_LOW_COUNT, 8'h80);
        wr(IDX_DBG, 8'h01);
        run_for(20);
        rd_val(IDX_LOW_COUNT, rv);
        check({31'h0, rv[7:0] != 8'h80}, 32'h1);
        cpu_halted <= 1'b0;
        wr(IDX_DBG, 8'h00);
        test_end("debug");
        // restart zeroes counters; slowest divider holds the count
        wr(IDX_ESET, 8'h08);
        rd_chk(IDX_LOW_COUNT, 8'h00);
        wr(IDX_LOW_COUNT, 8'h80);
        wr(IDX_CTRLA, 8'h0f);
        run_for(40);
        rd_chk(IDX_LOW_COUNT, 8'h80);
        test_end("divider");
        // three ticks at divide by one: high reloads its top, low steps down
        wr(IDX_CTRLA, 8'h01);
        wr(IDX_HIGH_TOP, 8'h05);
        wr(IDX_HIGH_COUNT, 8'h00);
        wr(IDX_LOW_COUNT, 8'h80);
        wr(IDX_LOW_CMP0, 8'h7e);
        wr(IDX_HIGH_CMP0, 8'h04);
        wr(IDX_CTRLB, 8'h11);
        run_for(0);
        rd_chk(IDX_HIGH_COUNT, 8'h03);
        rd_chk(IDX_LOW_COUNT, 8'h7d);
        rd_chk(IDX_FLAGS, 8'h10);
        check({26'h0, wave_out_pin}, 32'h1d);
        wr(IDX_HIGH_CMP0, 8'h03);
        wait_cyc(2);
        check({26'h0, wave_out_pin}, 32'h15);
        test_end("compare");
        // hard reset ignored while enabled, applied when disabled
        wr(IDX_LOW_TOP, 8'h33);
        wr(IDX_ESET, 8'h0c);
        rd_chk(IDX_LOW_TOP, 8'h33);
        wr(IDX_CTRLA, 8'h00);
        wr(IDX_ESET, 8'h0c);
        rd_chk(IDX_SPLIT, 8'h00);
        rd_chk(IDX_OVAL, 8'h00);
        test_end("hardreset");
        wrap_up();
    end
endmodule
